/* include/tpsr_pkg.sv */
// Shared constants and carriers for the port status register block.
package tpsr_pkg;

    // Register address of the port status register in the controller map.
    localparam logic [7:0] PORT_STATUS_ADDR = 8'h1a;
    // Register width in bits and in bytes.
    localparam int unsigned REG_BITS = 40;
    localparam int unsigned REG_BYTES = 5;
    // Reset value of the whole register: every field clears to zero.
    localparam logic [39:0] PORT_STATUS_RESET = 40'h00_0000_0000;

    // Field positions (least significant bit of each field).
    localparam int unsigned POS_SOC_ACK_TIMEOUT = 30;
    localparam int unsigned POS_SELF_TEST_ACTIVE = 27;
    localparam int unsigned POS_NON_PD_OPERATION = 24;
    localparam int unsigned POS_HOST_PRESENT = 22;
    localparam int unsigned POS_BUS_VOLTAGE_BAND = 20;
    localparam int unsigned POS_DATA_ROLE = 6;
    localparam int unsigned POS_POWER_ROLE = 5;
    localparam int unsigned POS_PLUG_ORIENT = 4;
    localparam int unsigned POS_CONN_STATE = 1;
    localparam int unsigned POS_PLUG_PRESENT = 0;

    // Time the port logic may take to settle on a non-PD verdict, in seconds.
    localparam int unsigned NON_PD_SETTLE_S = 10;

    // Non-PD operation encodings.
    localparam logic [1:0] NON_PD_NONE = 2'h0;
    localparam logic [1:0] NON_PD_SINK = 2'h1;
    localparam logic [1:0] NON_PD_SOURCE = 2'h2;
    localparam logic [1:0] NON_PD_SINK_DEAD_BATT = 2'h3;

    // Connection type encodings.
    localparam logic [2:0] CONN_NONE = 3'h0;
    localparam logic [2:0] CONN_DISABLED = 3'h1;
    localparam logic [2:0] CONN_AUDIO = 3'h2;
    localparam logic [2:0] CONN_DEBUG = 3'h3;
    localparam logic [2:0] CONN_RA_ONLY = 3'h4;
    localparam logic [2:0] CONN_RESERVED = 3'h5;
    localparam logic [2:0] CONN_NO_RA = 3'h6;
    localparam logic [2:0] CONN_WITH_RA = 3'h7;

    // Level conditions delivered by the port detection and policy logic.
    typedef struct packed {
        logic soc_ack_timeout;
        logic self_test_active;
        logic [1:0] non_pd_operation;
        logic [1:0] host_present;
        logic [1:0] bus_voltage_band;
        logic data_role;
        logic power_role;
        logic unattached;
        logic plug_orient;
        logic [2:0] conn_state;
        logic plug_present;
    } tpsr_status_s;

    // Host register access strobes and address.
    typedef struct packed {
        logic rd_start;
        logic rd_strobe;
        logic wr_strobe;
        logic [7:0] addr;
    } tpsr_access_s;

    // Read sequencer states.
    typedef enum logic [1:0] {
        RD_IDLE,
        RD_ACTIVE,
        RD_MISS
    } tpsr_rd_state_e;

endpackage

/* logic/tpsr_field_cond.sv */
// Conditions the raw port levels into the 40-bit register image.
module tpsr_field_cond (
    // Clock, reset and enable.
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    // Raw levels from the port logic.
    input wire tpsr_pkg::tpsr_status_s i_status,
    // Conditioned register image.
    output logic [39:0] o_image
);

    // Power role seen by software, held through unattached cycling.
    logic held_role;
    // Next held role.
    logic next_held_role;
    // Connection qualifier for the data role and orientation bits.
    wire connected = i_status.plug_present;
    // Combinational image before registering.
    logic [39:0] next_image;

    // hold power role
    // While the port cycles through unattached states the termination toggles; freezing the
    // role here keeps software from seeing that dither.
    assign next_held_role = i_status.unattached ? held_role : i_status.power_role;

    // Assemble the image; reserved positions stay zero.
    always_comb
    begin
        next_image = tpsr_pkg::PORT_STATUS_RESET;
        next_image[tpsr_pkg::POS_SOC_ACK_TIMEOUT] = i_status.soc_ack_timeout;
        next_image[tpsr_pkg::POS_SELF_TEST_ACTIVE] = i_status.self_test_active;
        next_image[tpsr_pkg::POS_NON_PD_OPERATION +: 2] = i_status.non_pd_operation;
        next_image[tpsr_pkg::POS_HOST_PRESENT +: 2] = i_status.host_present;
        next_image[tpsr_pkg::POS_BUS_VOLTAGE_BAND +: 2] = i_status.bus_voltage_band;
        next_image[tpsr_pkg::POS_DATA_ROLE] = connected & i_status.data_role;
        next_image[tpsr_pkg::POS_POWER_ROLE] = next_held_role;
        next_image[tpsr_pkg::POS_PLUG_ORIENT] = connected & i_status.plug_orient;
        next_image[tpsr_pkg::POS_CONN_STATE +: 3] = i_status.conn_state;
        next_image[tpsr_pkg::POS_PLUG_PRESENT] = i_status.plug_present;
    end

    // Register the image and the held role.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            o_image <= tpsr_pkg::PORT_STATUS_RESET;
            held_role <= 1'b0;
        end
        else if (i_ce)
        begin
            o_image <= next_image;
            held_role <= next_held_role;
        end
    end

endmodule

/* logic/tpsr_port_status.sv */
module tpsr_port_status (
    // Clock, reset and enable.
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    // Raw status levels from the port logic on the same clock.
    input wire tpsr_pkg::tpsr_status_s i_status,
    // Host register access.
    input wire tpsr_pkg::tpsr_access_s i_access,
    // Read answer.
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_rd_hit,
    // Write answer.
    output logic o_wr_ignored,
    // Live image for local observers.
    output logic [39:0] o_live
);

    // Conditioned live image from the field stage.
    logic [39:0] live_image;
    // Frozen image served during one host read.
    logic [39:0] snapshot;
    // Byte pointer within the snapshot, least significant byte first.
    logic [2:0] byte_ptr;
    // Read sequencer state.
    tpsr_pkg::tpsr_rd_state_e rd_state;
    // Next state of the read sequencer.
    tpsr_pkg::tpsr_rd_state_e next_rd_state;
    // Registered read answer and flags.
    logic [7:0] rd_data;
    logic rd_valid;
    logic rd_hit;
    logic wr_ignored;

    // Address decode for this register.
    wire addr_match = (i_access.addr == tpsr_pkg::PORT_STATUS_ADDR);
    // A read that begins at our address.
    wire start_hit = i_access.rd_start & addr_match;
    // A read that begins elsewhere in the map.
    wire start_miss = i_access.rd_start & ~addr_match;
    // Byte strobe while a read of this register is open.
    wire byte_take = i_access.rd_strobe & (rd_state == tpsr_pkg::RD_ACTIVE);
    // Byte pointer still within the register.
    wire ptr_in_range = (byte_ptr < 3'(tpsr_pkg::REG_BYTES));
    // Selected byte of the snapshot.
    wire [7:0] sel_byte = ptr_in_range ? snapshot[{byte_ptr, 3'h0} +: 8] : 8'h00;
    // Write aimed at this register.
    wire write_hit = i_access.wr_strobe & addr_match;

    // The field stage owns encoding, qualification and role hold.
    tpsr_field_cond u_field_cond (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_status(i_status),
        .o_image(live_image)
    );

    // Read sequencer: a start opens a read, a new start reopens it.
    always_comb
    begin
        next_rd_state = rd_state;
        case (rd_state)
            tpsr_pkg::RD_IDLE,
            tpsr_pkg::RD_ACTIVE,
            tpsr_pkg::RD_MISS:
            begin
                // A start always decides where the following bytes come from.
                if (start_hit)
                begin
                    next_rd_state = tpsr_pkg::RD_ACTIVE;
                end
                else if (start_miss)
                begin
                    next_rd_state = tpsr_pkg::RD_MISS;
                end
            end
            default:
            begin
                next_rd_state = tpsr_pkg::RD_IDLE;
            end
        endcase
    end

    // State register of the sequencer.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            rd_state <= tpsr_pkg::RD_IDLE;
        end
        else if (i_ce)
        begin
            rd_state <= next_rd_state;
        end
    end

    // Snapshot capture. Freezing at the start costs 40 flops but keeps the five bytes of one read
    // consistent when the port changes between byte reads.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            snapshot <= tpsr_pkg::PORT_STATUS_RESET;
        end
        else if (i_ce && start_hit)
        begin
            snapshot <= live_image;
        end
    end

    // Byte pointer: cleared by a start, stepped by each byte taken until it stops one past the last byte.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            byte_ptr <= 3'h0;
        end
        else if (i_ce)
        begin
            if (i_access.rd_start)
            begin
                byte_ptr <= 3'h0;
            end
            else if (byte_take && ptr_in_range)
            begin
                byte_ptr <= byte_ptr + 3'h1;
            end
        end
    end

    // Read answer. Bytes past the end and reads of other addresses return zero.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            rd_data <= 8'h00;
            rd_valid <= 1'b0;
            rd_hit <= 1'b0;
        end
        else if (i_ce)
        begin
            rd_data <= byte_take ? sel_byte : 8'h00;
            rd_valid <= i_access.rd_strobe;
            rd_hit <= byte_take;
        end
    end

    // Writes are accepted on the bus but change nothing here.
    always_ff @(posedge i_mclk)
    begin
        if (i_reset)
        begin
            wr_ignored <= 1'b0;
        end
        else if (i_ce)
        begin
            wr_ignored <= write_hit;
        end
    end

    // no interrupt path
    // Status changes only update the image; nothing here produces an event, so there is
    // deliberately no edge detection on any field.
    assign o_live = live_image;

    // non PD lag
    // The non-PD field is passed through as the policy logic reports it; its slow verdict
    // is that logic's concern and no timeout is imposed on it here.
    assign o_rd_data = rd_data;
    assign o_rd_valid = rd_valid;
    assign o_rd_hit = rd_hit;
    assign o_wr_ignored = wr_ignored;

endmodule

/* test/tpsr_host_model.sv */
// Host side: opens reads, strobes bytes and writes, all off the falling edge.
module tpsr_host_model (
    // Clock and answers.
    input wire logic i_mclk,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    input wire logic i_rd_hit,
    input wire logic i_wr_ignored,
    // Access strobes.
    output tpsr_pkg::tpsr_access_s o_access
);
    timeunit 1ns;
    timeprecision 1ps;
    initial o_access = '0;
    // Five bytes back to back, least significant first.
    task automatic read_reg(input logic [7:0] a, output logic [39:0] v, output logic hit);
        hit = 1'b1;
        @(negedge i_mclk);
        o_access.rd_start = 1'b1;
        o_access.addr = a;
        @(negedge i_mclk);
        o_access.rd_start = 1'b0;
        o_access.rd_strobe = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            @(negedge i_mclk);
            v[8*i +: 8] = i_rd_data;
            hit = hit & i_rd_hit & i_rd_valid;
        end
        o_access.rd_strobe = 1'b0;
        // A released address shows garbage, never the old value.
        o_access.addr = ~a;
    endtask
    task automatic write_reg(input logic [7:0] a, output logic ign);
        @(negedge i_mclk);
        o_access.wr_strobe = 1'b1;
        o_access.addr = a;
        @(negedge i_mclk);
        o_access.wr_strobe = 1'b0;
        o_access.addr = ~a;
        ign = i_wr_ignored;
    endtask
    // One lone byte strobe; its answer is taken one cycle later, on the next falling edge.
    task automatic strobe_byte(output logic [7:0] d, output logic h, output logic vld);
        @(negedge i_mclk);
        o_access.rd_strobe = 1'b1;
        @(negedge i_mclk);
        o_access.rd_strobe = 1'b0;
        d = i_rd_data;
        h = i_rd_hit;
        vld = i_rd_valid;
    endtask
endmodule

/* test/tpsr_port_status_properties.sv */
// Watches the port status register from its own ports.
module tpsr_chk (
    // Clock and control.
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    // Stimulus side.
    input wire tpsr_pkg::tpsr_status_s i_status,
    input wire tpsr_pkg::tpsr_access_s i_access,
    // Answers.
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_rd_hit,
    input wire logic o_wr_ignored,
    input wire logic [39:0] o_live
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);
    // Bit positions that carry no field and must read as zero.
    localparam logic [39:0] RSV = 40'hff_b40f_ff80;
    chk_reset_clear: assert property ($past(i_reset) |-> o_live == 40'h0 && !o_rd_valid)
        else $error("image not clear after reset");
    chk_ack_timeout: assert property (i_ce |=> o_live[30] == $past(i_status.soc_ack_timeout))
        else $error("ack timeout bit wrong");
    chk_self_test: assert property ($rose(i_status.self_test_active) && i_ce |=> o_live[27])
        else $error("self test bit missed");
    chk_non_pd: assert property (i_ce |=> o_live[25:24] == $past(i_status.non_pd_operation))
        else $error("non pd field wrong");
    chk_host_band: assert property (i_ce |=> o_live[23:20] == $past(i_status[11:8]))
        else $error("host or band field wrong");
    chk_role_gate: assert property (!i_status.plug_present && i_ce |=> !o_live[6] && !o_live[4])
        else $error("role or orientation shown without plug");
    chk_role_hold: assert property (i_ce && i_status.unattached |=> $stable(o_live[5]))
        else $error("power role moved while unattached");
    chk_role_follow: assert property (i_ce && !i_status.unattached |=> o_live[5] == $past(i_status.power_role))
        else $error("power role not followed");
    chk_conn_plug: assert property (i_ce |=> o_live[3:0] == $past(i_status[3:0]))
        else $error("connection or plug field wrong");
    chk_reserved_zero: assert property ((o_live & RSV) == 40'h0)
        else $error("reserved bit set");
    chk_write_ack: assert property (i_ce && i_access.wr_strobe && i_access.addr == 8'h1a |=> o_wr_ignored)
        else $error("write not acknowledged as ignored");
endmodule

bind tpsr_port_status tpsr_chk u_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_status(i_status),
    .i_access(i_access), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_rd_hit(o_rd_hit),
    .o_wr_ignored(o_wr_ignored), .o_live(o_live));

/* test/tpsr_port_status_tb.sv */
// Reads the status register through the host model and judges each image.
module tpsr_port_status_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic i_ce = 1'b1;
    tpsr_pkg::tpsr_status_s st = '0;
    tpsr_pkg::tpsr_access_s acc;
    logic [7:0] rd_data;
    logic rd_valid, rd_hit, wr_ign;
    logic [39:0] live, v;
    logic held_pr = 1'b0;
    logic hit;
    int fail_count = 0;
    int num_checks = 0;
    initial forever #2 i_mclk = ~i_mclk;
    tpsr_port_status u_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_ce(i_ce), .i_status(st), .i_access(acc),
        .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_rd_hit(rd_hit), .o_wr_ignored(wr_ign), .o_live(live));
    tpsr_host_model u_host (.i_mclk(i_mclk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .i_rd_hit(rd_hit),
        .i_wr_ignored(wr_ign), .o_access(acc));
    task automatic check(input logic [39:0] seen, input logic [39:0] want);
        num_checks++;
        if (seen !== want)
        begin
            fail_count++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    // Image worked out field by field; data role and orientation need a plug.
    function automatic logic [39:0] img(input tpsr_pkg::tpsr_status_s s, input logic pr);
        return {9'h0, s.soc_ack_timeout, 2'h0, s.self_test_active, 1'h0, s.non_pd_operation, s.host_present,
            s.bus_voltage_band, 13'h0, s.data_role & s.plug_present, pr, s.plug_orient & s.plug_present,
            s.conn_state, s.plug_present};
    endfunction
    task automatic apply(input tpsr_pkg::tpsr_status_s s);
        @(negedge i_mclk);
        st = s;
        if (!s.unattached)
            held_pr = s.power_role;
        repeat (2) @(negedge i_mclk);
    endtask
    task automatic read_expect(input logic [39:0] want);
        u_host.read_reg(tpsr_pkg::PORT_STATUS_ADDR, v, hit);
        check({39'h0, hit}, 40'h1);
        check(v, want);
    endtask
    task automatic test_fields();
        tpsr_pkg::tpsr_status_s s;
        for (int i = 0; i < 8; i++)
        begin
            s = '0;
            s.conn_state = 3'(i);
            s.non_pd_operation = 2'(i);
            s.host_present = ~2'(i);
            s.bus_voltage_band = 2'(i >> 1);
            s.soc_ack_timeout = i[0];
            s.self_test_active = i[1];
            s.power_role = i[2];
            s.data_role = 1'b1;
            s.plug_orient = 1'b1;
            s.plug_present = i[0];
            apply(s);
            read_expect(img(s, held_pr));
        end
    endtask
    task automatic test_role_hold();
        tpsr_pkg::tpsr_status_s s;
        s = '0;
        s.power_role = 1'b1;
        apply(s);
        read_expect(img(s, 1'b1));
        s.unattached = 1'b1;
        s.power_role = 1'b0;
        apply(s);
        read_expect(img(s, 1'b1));
        s.unattached = 1'b0;
        apply(s);
        read_expect(img(s, 1'b0));
    endtask
    task automatic test_write_unmapped();
        logic ign;
        u_host.write_reg(tpsr_pkg::PORT_STATUS_ADDR, ign);
        check({39'h0, ign}, 40'h1);
        read_expect(img(st, held_pr));
        u_host.read_reg(8'h1b, v, hit);
        check({hit, v[38:0]}, 40'h0);
    endtask
    // Status moves on the very edge the read opens; bytes must stay old.
    task automatic test_snapshot();
        tpsr_pkg::tpsr_status_s s;
        s = 16'ha5c7;
        apply(s);
        fork
            u_host.read_reg(tpsr_pkg::PORT_STATUS_ADDR, v, hit);
            begin
                @(negedge i_mclk);
                st = 16'h5a38;
            end
        join
        check(v, img(s, held_pr));
    endtask
    // Enable low freezes the image; a byte past the end reads zero; a stray strobe misses.
    task automatic test_freeze_tail();
        tpsr_pkg::tpsr_status_s s;
        logic [7:0] d;
        logic h, vld;
        s = 16'h0001;
        apply(s);
        @(negedge i_mclk);
        i_ce = 1'b0;
        st = 16'h8000;
        repeat (2) @(negedge i_mclk);
        check(live, img(s, held_pr));
        i_ce = 1'b1;
        s = 16'h8000;
        apply(s);
        check(live, img(s, held_pr));
        u_host.read_reg(tpsr_pkg::PORT_STATUS_ADDR, v, hit);
        u_host.strobe_byte(d, h, vld);
        check({30'h0, vld, h, d}, {30'h0, 2'h3, 8'h00});
        u_host.read_reg(8'h1b, v, hit);
        u_host.strobe_byte(d, h, vld);
        check({30'h0, vld, h, d}, {30'h0, 2'h2, 8'h00});
        // A reset in mid-run clears the image and the held role again.
        @(negedge i_mclk);
        i_reset = 1'b1;
        repeat (2) @(negedge i_mclk);
        i_reset = 1'b0;
        held_pr = 1'b0;
        check(live, 40'h0);
        read_expect(img(st, held_pr));
    endtask
    task automatic give_verdict();
        $display("checks %0d failures %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (4000) @(posedge i_mclk);
        fail_count++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(negedge i_mclk);
        i_reset = 1'b0;
        check(live, 40'h0);
        read_expect(40'h0);
        test_fields();
        test_role_hold();
        test_write_unmapped();
        test_snapshot();
        test_freeze_tail();
        give_verdict();
    end
endmodule
